// [inc/slcs_pkg.sv]
// Constants, types and helpers for the light curtain receiver sequencer
package slcs_pkg;

  localparam int unsigned SLCS_CLK_KHZ = 25000;
  localparam int unsigned SLCS_RESET_OPEN_MS = 250;
  localparam int unsigned SLCS_TEST_OPEN_MS = 200;
  localparam int unsigned SLCS_FLASH_HALF_MS = 250;
  localparam int unsigned SLCS_DEBOUNCE_MS = 10;

  // Least times round up; these come out exact at 25 MHz
  localparam int unsigned SLCS_RESET_OPEN_CYC =
    SLCS_CLK_KHZ * SLCS_RESET_OPEN_MS;
  localparam int unsigned SLCS_TEST_OPEN_CYC =
    SLCS_CLK_KHZ * SLCS_TEST_OPEN_MS;
  localparam int unsigned SLCS_FLASH_HALF_CYC =
    SLCS_CLK_KHZ * SLCS_FLASH_HALF_MS;
  localparam int unsigned SLCS_DEBOUNCE_CYC =
    SLCS_CLK_KHZ * SLCS_DEBOUNCE_MS;

  localparam int SLCS_CNT_W = 24;
  typedef logic [SLCS_CNT_W-1:0] slcs_cnt_t;

  localparam slcs_cnt_t SLCS_CNT_RST = 24'h000000;
  localparam logic SLCS_LEVEL_RST = 1'b0;
  localparam logic [2:0] SLCS_SYNC_RST = 3'h0;
  localparam logic [1:0] SLCS_OUT_RST = 2'h0;

  typedef enum logic [2:0] {
    SLCS_ST_SELFTEST = 3'h0,
    SLCS_ST_SYNC = 3'h1,
    SLCS_ST_WAIT = 3'h3,
    SLCS_ST_RUN = 3'h2,
    SLCS_ST_TEST = 3'h6,
    SLCS_ST_LOCKOUT = 3'h7,
    SLCS_ST_INFAULT = 3'h5
  } slcs_state_e;

  // Optical front end status, same clock domain
  typedef struct packed {
    logic sync_ok;
    logic top_clear;
    logic bottom_clear;
    logic all_clear;
  } slcs_beam_s;

  typedef struct packed {
    logic emit_power;
    logic align_top;
    logic align_bottom;
    logic status_clear;
    logic status_blocked;
  } slcs_led_s;

  localparam slcs_led_s SLCS_LED_RST = 5'h00;

  typedef struct packed {
    logic [2:0] sync;
    slcs_cnt_t cnt;
    logic level;
    logic settled;
  } slcs_filt_s;

  typedef struct packed {
    slcs_state_e st;
    logic latch_mode;
    logic emit_lock;
    slcs_cnt_t open_cnt;
    logic prev_level;
    slcs_cnt_t flash_cnt;
    logic flash;
    logic [1:0] safety_switch_output;
    slcs_led_s led;
  } slcs_seq_s;

  function automatic slcs_cnt_t slcs_sat_inc(input slcs_cnt_t v);
    slcs_cnt_t r;
    r = v;
    if (v != {SLCS_CNT_W{1'b1}}) begin
      r = v + 24'h000001;
    end
    return r;
  endfunction

endpackage

// [logic/slcs_pin_filter.sv]
// Three-stage synchroniser and debouncer for the reset/test pin
`timescale 1ns/100ps
module slcs_pin_filter
  import slcs_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYC = SLCS_DEBOUNCE_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic pin,
  output logic level,
  output logic settled
);

  slcs_filt_s q_reg;
  slcs_filt_s q_next;

  always_comb begin
    q_next = q_reg;
    q_next.sync = {q_reg.sync[1:0], pin};
    // Only stages two and three are compared; stage one feeds stage two only
    if (q_reg.sync[1] == q_reg.sync[2] &&
        (q_reg.sync[2] != q_reg.level || !q_reg.settled)) begin
      q_next.cnt = slcs_sat_inc(q_reg.cnt);
      if (q_reg.cnt >= DEBOUNCE_CYC[SLCS_CNT_W-1:0]) begin
        q_next.level = q_reg.sync[2];
        q_next.settled = 1'b1;
        q_next.cnt = SLCS_CNT_RST;
      end
    end else begin
      q_next.cnt = SLCS_CNT_RST;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q_reg.sync <= SLCS_SYNC_RST;
      q_reg.cnt <= SLCS_CNT_RST;
      q_reg.level <= SLCS_LEVEL_RST;
      q_reg.settled <= 1'b0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign level = q_reg.level;
  assign settled = q_reg.settled;

endmodule

// [logic/slcs_sequencer.sv]
// Receiver sequencing, safety outputs and indicator drive
// Overview of operation
// - Reset accepted only after a quarter second open, then closing.
// - Trip variant needs manual reset only to leave lockout.
// - Latch variant needs reset after power-up, latch events and lockout.
// - Emitter fault locks until power cycle; no reset input exists.
// - Emitter green on when healthy, flashing on fault.
// - Top yellow on while sync beam aligned and clear.
// - Bottom yellow on while bottom beam aligned and clear.
// - Latch variant flashes both yellows while aligned, awaiting reset.
// - Green on when clear with outputs on; flashes in test while red stays on.
// - Red on when blocked with outputs off; flashes in lockout.
// - Power-up self-test fault stops scanning, outputs off, diagnostics.
// - Trip variant enters run after sync without any reset.
// - Latch variant waits for aligned beams and valid reset before run.
// - Trip run: blocked beam drops outputs, clear beams restore them.
// - Latch run: block drops outputs; need reset with beams still clear.
// - Runtime critical fault stops scanning, drops outputs, shows lockout.
// - Reset/test input open over 200 ms runs test cycle, outputs off.
// - Input open at power-up gives input fault: red, green on.
`timescale 1ns/100ps
module slcs_sequencer
  import slcs_pkg::*;
#(
  parameter int unsigned RESET_OPEN_CYC = SLCS_RESET_OPEN_CYC,
  parameter int unsigned TEST_OPEN_CYC = SLCS_TEST_OPEN_CYC,
  parameter int unsigned FLASH_HALF_CYC = SLCS_FLASH_HALF_CYC,
  parameter int unsigned DEBOUNCE_CYC = SLCS_DEBOUNCE_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic latch_mode,
  input wire logic reset_test_in,
  input wire slcs_beam_s beam,
  input wire logic selftest_done,
  input wire logic selftest_fault,
  input wire logic internal_fault,
  input wire logic emitter_fault,
  output logic safety_switch_output_1,
  output logic safety_switch_output_2,
  output logic scan_enable,
  output slcs_state_e state,
  output slcs_led_s led
);

  localparam slcs_cnt_t RESET_OPEN_LIM = RESET_OPEN_CYC[SLCS_CNT_W-1:0];
  localparam slcs_cnt_t TEST_OPEN_LIM = TEST_OPEN_CYC[SLCS_CNT_W-1:0];
  localparam slcs_cnt_t FLASH_LAST = FLASH_HALF_CYC[SLCS_CNT_W-1:0] -
    24'h000001;

  slcs_seq_s q_reg;
  slcs_seq_s q_next;
  logic in_closed;
  logic in_settled;
  logic reset_pulse;
  logic fault;
  logic outs_on;
  logic latch_eff;

  slcs_pin_filter #(
    .DEBOUNCE_CYC(DEBOUNCE_CYC)
  ) u_filter (
    .mclk(mclk),
    .resetn(resetn),
    .pin(reset_test_in),
    .level(in_closed),
    .settled(in_settled)
  );

  assign fault = internal_fault | selftest_fault;
  // The strap is frozen once self-test ends
  assign latch_eff = (q_reg.st == SLCS_ST_SELFTEST) ? latch_mode :
    q_reg.latch_mode;
  // Acts on the closing edge that ends a long enough open interval
  assign reset_pulse = in_closed & ~q_reg.prev_level &
    (q_reg.open_cnt >= RESET_OPEN_LIM);

  always_comb begin
    q_next = q_reg;
    outs_on = 1'b0;
    q_next.prev_level = in_closed;
    if (!in_closed) begin
      q_next.open_cnt = slcs_sat_inc(q_reg.open_cnt);
    end else begin
      q_next.open_cnt = SLCS_CNT_RST;
    end
    if (q_reg.flash_cnt >= FLASH_LAST) begin
      q_next.flash_cnt = SLCS_CNT_RST;
      q_next.flash = ~q_reg.flash;
    end else begin
      q_next.flash_cnt = slcs_sat_inc(q_reg.flash_cnt);
    end
    // Sticky until power is removed; nothing else clears it
    if (emitter_fault) begin
      q_next.emit_lock = 1'b1;
    end

    unique case (q_reg.st)
      SLCS_ST_SELFTEST: begin
        q_next.latch_mode = latch_eff;
        if (fault) begin
          q_next.st = SLCS_ST_LOCKOUT;
        end else if (selftest_done && in_settled) begin
          if (!in_closed) begin
            q_next.st = SLCS_ST_INFAULT;
          end else begin
            q_next.st = SLCS_ST_SYNC;
          end
        end
      end
      SLCS_ST_SYNC: begin
        if (fault) begin
          q_next.st = SLCS_ST_LOCKOUT;
        end else if (beam.sync_ok) begin
          q_next.st = q_reg.latch_mode ? SLCS_ST_WAIT : SLCS_ST_RUN;
        end
      end
      SLCS_ST_WAIT: begin
        if (fault) begin
          q_next.st = SLCS_ST_LOCKOUT;
        end else if (!beam.sync_ok) begin
          q_next.st = SLCS_ST_SYNC;
        end else if (reset_pulse && beam.all_clear) begin
          q_next.st = SLCS_ST_RUN;
        end
      end
      SLCS_ST_RUN: begin
        if (fault) begin
          q_next.st = SLCS_ST_LOCKOUT;
        end else if (q_reg.open_cnt > TEST_OPEN_LIM) begin
          q_next.st = SLCS_ST_TEST;
        end else if (!beam.sync_ok) begin
          q_next.st = SLCS_ST_SYNC;
        end else if (q_reg.latch_mode && !beam.all_clear) begin
          q_next.st = SLCS_ST_WAIT;
        end
      end
      SLCS_ST_TEST: begin
        if (fault) begin
          q_next.st = SLCS_ST_LOCKOUT;
        end else if (in_closed) begin
          q_next.st = q_reg.latch_mode ? SLCS_ST_WAIT : SLCS_ST_SYNC;
        end
      end
      SLCS_ST_LOCKOUT: begin
        // A reset is ignored while the fault is still present
        if (reset_pulse && !fault) begin
          q_next.st = SLCS_ST_SYNC;
        end
      end
      SLCS_ST_INFAULT: begin
        q_next.st = SLCS_ST_INFAULT;
      end
      default: begin
        q_next.st = SLCS_ST_LOCKOUT;
      end
    endcase

    q_next.led.emit_power = q_next.emit_lock ? q_next.flash : 1'b1;
    q_next.led.align_top = beam.sync_ok & beam.top_clear;
    q_next.led.align_bottom = beam.sync_ok & beam.bottom_clear;
    q_next.led.status_clear = 1'b0;
    q_next.led.status_blocked = 1'b1;
    unique case (q_next.st)
      SLCS_ST_RUN: begin
        // Trip variant stays here while blocked and recovers by itself
        outs_on = beam.all_clear & beam.sync_ok;
        q_next.led.status_clear = outs_on;
        q_next.led.status_blocked = ~outs_on;
      end
      SLCS_ST_WAIT: begin
        if (beam.all_clear && beam.sync_ok) begin
          q_next.led.align_top = q_next.flash;
          q_next.led.align_bottom = q_next.flash;
        end
      end
      SLCS_ST_TEST: begin
        q_next.led.status_clear = q_next.flash;
      end
      SLCS_ST_LOCKOUT: begin
        q_next.led.align_top = 1'b0;
        q_next.led.align_bottom = 1'b0;
        q_next.led.status_blocked = q_next.flash;
      end
      SLCS_ST_INFAULT: begin
        q_next.led.align_top = 1'b0;
        q_next.led.align_bottom = 1'b0;
        q_next.led.status_clear = 1'b1;
      end
      default: begin
        outs_on = 1'b0;
      end
    endcase
    q_next.safety_switch_output = {outs_on, outs_on};
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q_reg.st <= SLCS_ST_SELFTEST;
      q_reg.latch_mode <= 1'b0;
      q_reg.emit_lock <= 1'b0;
      q_reg.open_cnt <= SLCS_CNT_RST;
      q_reg.prev_level <= SLCS_LEVEL_RST;
      q_reg.flash_cnt <= SLCS_CNT_RST;
      q_reg.flash <= 1'b0;
      q_reg.safety_switch_output <= SLCS_OUT_RST;
      q_reg.led <= SLCS_LED_RST;
    end else begin
      q_reg <= q_next;
    end
  end

  assign safety_switch_output_1 = q_reg.safety_switch_output[0];
  assign safety_switch_output_2 = q_reg.safety_switch_output[1];
  // Scanning stops for self-test, lockout and input fault
  assign scan_enable = (q_reg.st != SLCS_ST_LOCKOUT) &&
    (q_reg.st != SLCS_ST_INFAULT) && (q_reg.st != SLCS_ST_SELFTEST);
  assign state = q_reg.st;
  assign led = q_reg.led;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  AST_OUTS_EQUAL: assert property (
    safety_switch_output_1 == safety_switch_output_2)
    else $error("safety outputs differ");

  AST_OFF_OUTSIDE_RUN: assert property (
    (q_reg.st != SLCS_ST_RUN) |-> !safety_switch_output_1)
    else $error("safety output on outside run");

  AST_FAULT_LOCKOUT: assert property (
    (fault && q_reg.st != SLCS_ST_INFAULT) |=>
      (q_reg.st == SLCS_ST_LOCKOUT) && !safety_switch_output_1 &&
      !scan_enable)
    else $error("fault did not lock out");

  AST_SELFTEST_FAULT: assert property (
    (q_reg.st == SLCS_ST_SELFTEST && selftest_fault) |=>
      (q_reg.st == SLCS_ST_LOCKOUT) [*2])
    else $error("self-test fault not held in lockout");

  AST_TRIP_BLOCK: assert property (
    (q_reg.st == SLCS_ST_RUN && !q_reg.latch_mode && !beam.all_clear &&
     !fault) |=> !safety_switch_output_1 && led.status_blocked)
    else $error("trip run did not drop outputs on block");

  AST_TRIP_AUTO: assert property (
    (q_reg.st == SLCS_ST_SYNC && !q_reg.latch_mode && beam.sync_ok &&
     !fault) |=> (q_reg.st == SLCS_ST_RUN))
    else $error("trip variant did not enter run after sync");

  AST_LATCH_HOLD: assert property (
    (q_reg.st == SLCS_ST_WAIT && !reset_pulse && !fault) |=>
      (q_reg.st != SLCS_ST_RUN) && !safety_switch_output_1)
    else $error("latch left wait without reset");

  AST_RESET_QUAL: assert property (
    (q_reg.st == SLCS_ST_LOCKOUT && in_closed && !q_reg.prev_level &&
     q_reg.open_cnt < RESET_OPEN_LIM) |=> (q_reg.st == SLCS_ST_LOCKOUT))
    else $error("reset accepted after short open interval");

  AST_TEST_CYCLE: assert property (
    (q_reg.st == SLCS_ST_RUN && q_reg.open_cnt > TEST_OPEN_LIM && !fault)
      |=> (q_reg.st == SLCS_ST_TEST) && !safety_switch_output_1 &&
      led.status_blocked)
    else $error("long open input did not start test cycle");

  AST_INPUT_FAULT: assert property (
    (q_reg.st == SLCS_ST_INFAULT) |=> (q_reg.st == SLCS_ST_INFAULT) &&
      led.status_clear && led.status_blocked && !led.align_top)
    else $error("input fault not held");

  AST_ALIGN_FLASH: assert property (
    (q_next.st == SLCS_ST_WAIT && beam.all_clear && beam.sync_ok) |=>
      led.align_top == led.align_bottom)
    else $error("alignment indicators not in unison");

  AST_EMIT_FLASH: assert property (
    q_reg.emit_lock |=> q_reg.emit_lock && (led.emit_power == q_reg.flash))
    else $error("emitter lockout not held or not flashing");

  AST_EMIT_ON: assert property (
    (!q_reg.emit_lock && !emitter_fault) |=> led.emit_power)
    else $error("emitter indicator dark while healthy");

  AST_ALIGN_TOP: assert property (
    (q_reg.st == SLCS_ST_RUN && !fault) |=>
      led.align_top == $past(beam.sync_ok && beam.top_clear))
    else $error("top alignment indicator wrong in run");

  AST_ALIGN_BOTTOM: assert property (
    (q_reg.st == SLCS_ST_RUN && !fault) |=>
      led.align_bottom == $past(beam.sync_ok && beam.bottom_clear))
    else $error("bottom alignment indicator wrong in run");

  AST_RUN_STATUS: assert property (
    (q_reg.st == SLCS_ST_RUN) |->
      (led.status_clear == safety_switch_output_1) &&
      (led.status_blocked != safety_switch_output_1))
    else $error("status indicators disagree with outputs");

  AST_LOCK_LEDS: assert property (
    (q_reg.st == SLCS_ST_LOCKOUT) |-> !led.status_clear &&
      !led.align_top && !led.align_bottom &&
      (led.status_blocked == q_reg.flash))
    else $error("lockout indicator pattern wrong");

  AST_LOCK_HOLD: assert property (
    (q_reg.st == SLCS_ST_LOCKOUT && !reset_pulse) |=>
      (q_reg.st == SLCS_ST_LOCKOUT))
    else $error("lockout left without reset");

  AST_WAIT_TO_RUN: assert property (
    (q_reg.st == SLCS_ST_WAIT && reset_pulse && beam.all_clear &&
     beam.sync_ok && !fault) |=>
      (q_reg.st == SLCS_ST_RUN) && safety_switch_output_1)
    else $error("valid reset did not start run");

endmodule

// [verification/slcs_switch_model.sv]
// Operator reset switch: holds the contact open for a requested time
`timescale 1ns/100ps
module slcs_switch_model (
  input wire logic mclk,
  input wire logic start,
  input wire logic [15:0] open_len,
  output logic pin,
  output logic busy
);
  int left = 0;

  // Contact moves just after a rising edge, then holds for the whole count
  always @(posedge mclk) begin
    if (start && left == 0) begin
      left <= int'(open_len);
    end else if (left > 0) begin
      left <= left - 1;
    end
  end

  // Closed contact ties the pin high; open pulls it low
  assign pin = (left == 0);
  assign busy = (left != 0);
endmodule

// [verification/tb.sv]
// Self-checking bench for the light curtain receiver sequencer
`timescale 1ns/100ps
module tb;
  import slcs_pkg::*;
  logic mclk = 1'h0;
  logic resetn = 1'h0;
  logic latch_mode = 1'h0;
  slcs_beam_s beam = 4'hF;
  logic selftest_done = 1'h0;
  logic selftest_fault = 1'h0;
  logic internal_fault = 1'h0;
  logic emitter_fault = 1'h0;
  logic sw_start = 1'h0;
  logic [15:0] sw_len = 16'h0000;
  logic pin, sw_busy, sso1, sso2, scan_en;
  logic [1:0] seen;
  logic [31:0] rng = 32'h000087A3;
  logic [31:0] r;
  slcs_state_e state;
  slcs_led_s led;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  int exp_q[$];

  // Short counts keep the run brief; test open stays below reset open
  slcs_sequencer #(.RESET_OPEN_CYC(40), .TEST_OPEN_CYC(30),
    .FLASH_HALF_CYC(4), .DEBOUNCE_CYC(3)) i_slcs_sequencer (
    .mclk(mclk), .resetn(resetn), .latch_mode(latch_mode),
    .reset_test_in(pin), .beam(beam), .selftest_done(selftest_done),
    .selftest_fault(selftest_fault), .internal_fault(internal_fault),
    .emitter_fault(emitter_fault), .safety_switch_output_1(sso1),
    .safety_switch_output_2(sso2), .scan_enable(scan_en),
    .state(state), .led(led));

  slcs_switch_model i_slcs_switch_model (.mclk(mclk), .start(sw_start),
    .open_len(sw_len), .pin(pin), .busy(sw_busy));

  always #20 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic close_out();
    $display("samples_checked %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic chk_out(input logic on);
    chk({6'h00, sso1, sso2}, {6'h00, on, on}, "safety outputs");
  endtask

  task automatic wait_st(input slcs_state_e s, input int lim);
    int i;
    for (i = 0; i < lim && state !== s; i++) begin
      tick(1);
    end
    chk({5'h00, state}, {5'h00, s}, "state");
  endtask

  // Switch request held until the model has taken it at a rising edge
  task automatic press(input int len, input bit wt);
    int i;
    sw_len = 16'(len);
    sw_start = 1'h1;
    tick(1);
    sw_start = 1'h0;
    for (i = 0; i < 500 && wt && sw_busy !== 1'h0; i++) begin
      tick(1);
    end
  endtask

  task automatic power_up(input logic lm, input logic stf);
    resetn = 1'h0;
    latch_mode = lm;
    selftest_fault = stf;
    selftest_done = 1'h0;
    beam = 4'hF;
    tick(6);
    resetn = 1'h1;
    tick(2);
    selftest_done = 1'h1;
  endtask

  task automatic flash_seen(input int sel);
    int k;
    seen = 2'h0;
    for (k = 0; k < 12; k++) begin
      tick(1);
      if (led[sel] === 1'h1) seen[1] = 1'h1;
      if (led[sel] === 1'h0) seen[0] = 1'h1;
      if (sel == 3) chk({7'h00, led[3]}, {7'h00, led[2]}, "align pair");
    end
  endtask

  initial begin
    power_up(1'h0, 1'h0);
    wait_st(SLCS_ST_RUN, 60);
    tick(1);
    chk_out(1'h1);
    // Random beam patterns in trip run, sync held
    for (int i = 0; i < 40; i++) begin
      rng = xs(rng);
      r = rng;
      beam = {1'h1, r[0], r[1], r[0] & r[1] & r[2]};
      exp_q.push_back({27'h0, 1'h1, r[0], r[1], &r[2:0], ~&r[2:0]});
      tick(1);
      chk_out(beam.all_clear);
      chk({3'h0, led}, 8'(exp_q.pop_front()), "leds");
    end
    // Losing the sync beam drops the outputs and restarts the search
    beam = 4'h7;
    tick(1);
    chk({5'h00, state}, {5'h00, SLCS_ST_SYNC}, "sync lost");
    chk_out(1'h0);
    beam = 4'hF;
    tick(2);
    press(10, 1'h1);
    tick(20);
    chk({5'h00, state}, {5'h00, SLCS_ST_RUN}, "short open");
    press(45, 1'h0);
    wait_st(SLCS_ST_TEST, 60);
    chk_out(1'h0);
    chk({7'h00, led.status_blocked}, 8'h01, "test red");
    wait_st(SLCS_ST_RUN, 80);
    internal_fault = 1'h1;
    tick(2);
    chk({5'h00, state}, {5'h00, SLCS_ST_LOCKOUT}, "lockout");
    chk({5'h00, sso1, scan_en, led.status_clear}, 8'h00, "lock outs");
    internal_fault = 1'h0;
    tick(8);
    chk({5'h00, state}, {5'h00, SLCS_ST_LOCKOUT}, "stays locked");
    press(10, 1'h1);
    tick(20);
    chk({5'h00, state}, {5'h00, SLCS_ST_LOCKOUT}, "short reset");
    press(50, 1'h1);
    wait_st(SLCS_ST_RUN, 60);
    chk({7'h00, led.emit_power}, 8'h01, "emitter on");
    emitter_fault = 1'h1;
    tick(1);
    emitter_fault = 1'h0;
    flash_seen(4);
    chk({6'h00, seen}, 8'h03, "emitter flash");
    press(50, 1'h1);
    flash_seen(4);
    chk({6'h00, seen}, 8'h03, "emitter still locked");
    power_up(1'h1, 1'h0);
    wait_st(SLCS_ST_WAIT, 60);
    chk_out(1'h0);
    flash_seen(3);
    chk({6'h00, seen}, 8'h03, "align flash");
    press(50, 1'h1);
    wait_st(SLCS_ST_RUN, 30);
    tick(1);
    chk_out(1'h1);
    beam = 4'hE;
    tick(2);
    chk({5'h00, state}, {5'h00, SLCS_ST_WAIT}, "latch");
    chk_out(1'h0);
    beam = 4'hF;
    tick(5);
    chk_out(1'h0);
    beam = 4'hE;
    press(50, 1'h1);
    tick(15);
    chk({5'h00, state}, {5'h00, SLCS_ST_WAIT}, "blocked reset");
    beam = 4'hF;
    press(50, 1'h1);
    wait_st(SLCS_ST_RUN, 30);
    power_up(1'h0, 1'h1);
    wait_st(SLCS_ST_LOCKOUT, 40);
    chk_out(1'h0);
    power_up(1'h0, 1'h0);
    press(300, 1'h0);
    wait_st(SLCS_ST_INFAULT, 60);
    tick(1);
    chk({3'h0, led}, 8'h13, "input fault leds");
    chk_out(1'h0);
    press(1, 1'h1);
    tick(20);
    chk({5'h00, state}, {5'h00, SLCS_ST_INFAULT}, "fault held");
    close_out();
  end
endmodule
